// File: core/acf_pkg.sv
// ==========================================================================
// Shared constants and types for the action command filter
// ==========================================================================
package acf_pkg;

  // Field widths of a received action message
  localparam int ACF_DEV_KEY_W   = 32;
  localparam int ACF_GRP_KEY_W   = 32;
  localparam int ACF_GRP_MASK_W  = 32;

  // Default number of action signals and queue depth
  localparam int ACF_NUM_SIGNALS = 4;
  localparam int ACF_QUEUE_DEPTH = 0;

  // Reset values of the stored keys and masks
  localparam logic [31:0] ACF_DEV_KEY_RST  = 32'h0000_0000;
  localparam logic [31:0] ACF_GRP_KEY_RST  = 32'h0000_0000;
  localparam logic [31:0] ACF_GRP_MASK_RST = 32'h0000_0000;

  // Latency from message strobe to action pulse, in cycles
  localparam int ACF_MATCH_LAT = 1;

  // Message evaluation state
  typedef enum logic [0:0] {
    ACF_IDLE,
    ACF_EVAL
  } acf_state_t;

endpackage : acf_pkg

// File: core/acf_sig_match.sv
`timescale 1ns/100ps
// ==========================================================================
// Per-signal group match: mask overlap and group key equality
// ==========================================================================
module acf_sig_match
  import acf_pkg::*;
#(
  parameter int KEY_W  = ACF_GRP_KEY_W,
  parameter int MASK_W = ACF_GRP_MASK_W
) (
  input  wire logic [KEY_W-1:0]  msg_group_key,
  input  wire logic [MASK_W-1:0] msg_group_mask,
  input  wire logic [KEY_W-1:0]  group_match_key,
  input  wire logic [MASK_W-1:0] group_filter_mask,
  output logic                   group_hit
);

  logic mask_ok;
  logic key_ok;

  // Both group conditions must hold for this signal
  always_comb begin
    mask_ok   = |(msg_group_mask & group_filter_mask); // [R5]
    key_ok    = (msg_group_key == group_match_key);    // [R6]
    group_hit = mask_ok && key_ok;
  end

endmodule : acf_sig_match

// File: core/acf_action_filter.sv
`timescale 1ns/100ps
// Overview of operation
// R1: Unconditional setting on lets commands pass with control channel closed.
// R2: Write-only device key must equal message device key to fire anything.
// R3: Read-only queue depth reports most scheduled commands pending at once.
// R4: Signal index selector picks which signal's key and mask are accessed.
// R5: Mask condition met when message mask AND stored mask is non-zero.
// R6: Group condition met when message group key equals stored group key.
// R7: Signal fires only when device key, mask and group key all match.
// R8: Host message carries device key, group key and group mask.
// R9: Raised signals route internally like digital input lines.
// R10: Accepted message gives one-cycle pulse per matching signal; else none.
module acf_action_filter
  import acf_pkg::*;
#(
  parameter int NUM_SIGNALS = ACF_NUM_SIGNALS,
  parameter int QUEUE_DEPTH = ACF_QUEUE_DEPTH,
  parameter int SEL_W       = (NUM_SIGNALS > 1) ? $clog2(NUM_SIGNALS) : 1
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // Incoming action message, one-cycle strobe
  input  wire logic                      msg_valid,
  input  wire logic [ACF_DEV_KEY_W-1:0]  msg_device_key,
  input  wire logic [ACF_GRP_KEY_W-1:0]  msg_group_key,
  input  wire logic [ACF_GRP_MASK_W-1:0] msg_group_mask,
  // Primary control channel open status
  input  wire logic                      ctrl_channel_open,
  // Configuration
  input  wire logic                      unconditional_cmd_setting,
  input  wire logic                      device_key_wr,
  input  wire logic [ACF_DEV_KEY_W-1:0]  device_match_key,
  input  wire logic                      sel_wr,
  input  wire logic [SEL_W-1:0]          signal_index_select_in,
  output logic [SEL_W-1:0]               signal_index_select,
  input  wire logic                      group_key_wr,
  input  wire logic [ACF_GRP_KEY_W-1:0]  group_match_key_in,
  output logic [ACF_GRP_KEY_W-1:0]       group_match_key,
  input  wire logic                      group_mask_wr,
  input  wire logic [ACF_GRP_MASK_W-1:0] group_filter_mask_in,
  output logic [ACF_GRP_MASK_W-1:0]      group_filter_mask,
  output logic [31:0]                    scheduled_queue_depth,
  // Action signals, sourced like input lines
  output logic [NUM_SIGNALS-1:0]         action_signal
);

  // ========================================================================
  // Configuration storage
  // ========================================================================
  logic [ACF_DEV_KEY_W-1:0]  dev_key_r,  dev_key_nxt;
  logic [SEL_W-1:0]          sel_r,      sel_nxt;
  logic [ACF_GRP_KEY_W-1:0]  gkey_r  [NUM_SIGNALS];
  logic [ACF_GRP_KEY_W-1:0]  gkey_nxt[NUM_SIGNALS];
  logic [ACF_GRP_MASK_W-1:0] gmask_r  [NUM_SIGNALS];
  logic [ACF_GRP_MASK_W-1:0] gmask_nxt[NUM_SIGNALS];

  // Device key has no readback path: write-only by construction
  always_comb begin
    dev_key_nxt = dev_key_r;
    if (device_key_wr) begin
      dev_key_nxt = device_match_key; // [R2]
    end
    sel_nxt = sel_r;
    if (sel_wr) begin
      sel_nxt = signal_index_select_in; // [R4]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dev_key_r <= ACF_DEV_KEY_RST;
      sel_r     <= '0;
    end else begin
      dev_key_r <= dev_key_nxt;
      sel_r     <= sel_nxt;
    end
  end

  // Per-signal keys and masks, written through the selector
  logic [NUM_SIGNALS-1:0] grp_hit;

  for (genvar i = 0; i < NUM_SIGNALS; i++) begin : g_sig
    always_comb begin
      gkey_nxt[i]  = gkey_r[i];
      gmask_nxt[i] = gmask_r[i];
      if (group_key_wr && (sel_r == SEL_W'(i))) begin
        gkey_nxt[i] = group_match_key_in; // [R4] [R6]
      end
      if (group_mask_wr && (sel_r == SEL_W'(i))) begin
        gmask_nxt[i] = group_filter_mask_in; // [R4] [R5]
      end
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        gkey_r[i]  <= ACF_GRP_KEY_RST;
        gmask_r[i] <= ACF_GRP_MASK_RST;
      end else begin
        gkey_r[i]  <= gkey_nxt[i];
        gmask_r[i] <= gmask_nxt[i];
      end
    end

    acf_sig_match u_match (
      .msg_group_key     (msg_group_key),
      .msg_group_mask    (msg_group_mask),
      .group_match_key   (gkey_r[i]),
      .group_filter_mask (gmask_r[i]),
      .group_hit         (grp_hit[i])
    );
  end

  // ========================================================================
  // Readback
  // ========================================================================
  // Out-of-range selector reads zero rather than aliasing another signal
  always_comb begin
    signal_index_select = sel_r;
    group_match_key     = '0;
    group_filter_mask   = '0;
    for (int k = 0; k < NUM_SIGNALS; k++) begin
      if (sel_r == SEL_W'(k)) begin
        group_match_key   = gkey_r[k];  // [R4]
        group_filter_mask = gmask_r[k]; // [R4]
      end
    end
    scheduled_queue_depth = 32'(QUEUE_DEPTH); // [R3]
  end

  // ========================================================================
  // Message evaluation
  // ========================================================================
  logic                   accept;
  logic                   dev_ok;
  logic [NUM_SIGNALS-1:0] pulse_r, pulse_nxt;

  // Channel gate: closed channel blocks unless unconditional is on
  always_comb begin
    dev_ok = (msg_device_key == dev_key_r); // [R2]
    accept = msg_valid && dev_ok &&
             (ctrl_channel_open || unconditional_cmd_setting); // [R1]
    pulse_nxt = '0;
    if (accept) begin
      pulse_nxt = grp_hit; // [R7]
    end
  end

  // Registered pulse; reloaded each cycle, so it lasts one cycle per accepted message
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulse_r <= '0;
    end else begin
      pulse_r <= pulse_nxt; // [R10]
    end
  end

  assign action_signal = pulse_r; // [R9]

  // ========================================================================
  // Checks
  // ========================================================================
  sequence s_match(int j);
    msg_valid && (msg_device_key == dev_key_r) && grp_hit[j] &&
      (ctrl_channel_open || unconditional_cmd_setting);
  endsequence

  a_pulse_on_match: assert property ( // [R7]
    @(posedge mclk) disable iff (!rst_n)
    s_match(0) |=> action_signal[0])
    else $error("matching message did not pulse signal 0");

  a_no_pulse_reject: assert property ( // [R10]
    @(posedge mclk) disable iff (!rst_n)
    !msg_valid |=> (action_signal == '0))
    else $error("pulse without a message");

  a_devkey_block: assert property ( // [R2]
    @(posedge mclk) disable iff (!rst_n)
    (msg_device_key != dev_key_r) |=> (action_signal == '0))
    else $error("pulse despite device key mismatch");

  a_channel_gate: assert property ( // [R1]
    @(posedge mclk) disable iff (!rst_n)
    (!ctrl_channel_open && !unconditional_cmd_setting)
      |=> (action_signal == '0))
    else $error("pulse while channel closed and not unconditional");

  a_uncond_pass: assert property ( // [R1]
    @(posedge mclk) disable iff (!rst_n)
    (s_match(0) ##0 !ctrl_channel_open) |=> action_signal[0])
    else $error("unconditional mode did not pass command");

  a_mask_zero: assert property ( // [R5]
    @(posedge mclk) disable iff (!rst_n)
    ((msg_group_mask & gmask_r[0]) == '0) |=> !action_signal[0])
    else $error("pulse with zero mask overlap");

  a_gkey_mismatch: assert property ( // [R6]
    @(posedge mclk) disable iff (!rst_n)
    (msg_group_key != gkey_r[0]) |=> !action_signal[0])
    else $error("pulse with group key mismatch");

  a_single_pulse: assert property ( // [R10]
    @(posedge mclk) disable iff (!rst_n)
    (action_signal[0] && !$past(msg_valid, 1)) |-> 1'b0)
    else $error("pulse not tied to the previous message");

  a_sel_write: assert property ( // [R4]
    @(posedge mclk) disable iff (!rst_n)
    (sel_wr && group_key_wr == 1'b0) |=>
      (signal_index_select == $past(signal_index_select_in)))
    else $error("selector write not taken");

  a_queue_const: assert property ( // [R3]
    @(posedge mclk) disable iff (!rst_n)
    scheduled_queue_depth == 32'(QUEUE_DEPTH))
    else $error("queue depth changed");

  // Every signal follows its own match result, not only signal 0
  for (genvar j = 0; j < NUM_SIGNALS; j++) begin : g_chk
    a_pulse_each: assert property ( // [R7]
      @(posedge mclk) disable iff (!rst_n)
      s_match(j) |=> action_signal[j])
      else $error("matching message did not pulse its signal");

    a_miss_quiet: assert property ( // [R10]
      @(posedge mclk) disable iff (!rst_n)
      !grp_hit[j] |=> !action_signal[j])
      else $error("pulse on a signal whose group did not match");
  end

endmodule : acf_action_filter

// File: dv/acf_host_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Host side: issues broadcast action messages
// ==========================================================================
module acf_host_model
  import acf_pkg::*;
(
  output logic                      msg_valid,
  output logic [ACF_DEV_KEY_W-1:0]  msg_device_key,
  output logic [ACF_GRP_KEY_W-1:0]  msg_group_key,
  output logic [ACF_GRP_MASK_W-1:0] msg_group_mask
);
  // Quiet bus at time zero
  initial begin
    msg_valid      = 1'b0;
    msg_device_key = 32'h0;
    msg_group_key  = 32'h0;
    msg_group_mask = 32'h0;
  end

  // Every message carries all three fields together
  task automatic send(input logic [31:0] dk, gk, gm);
    msg_valid      = 1'b1;
    msg_device_key = dk;
    msg_group_key  = gk;
    msg_group_mask = gm;
  endtask : send

  // Released fields flip, so stale data can never look like a match
  task automatic idle();
    msg_valid      = 1'b0;
    msg_device_key = ~msg_device_key;
    msg_group_key  = ~msg_group_key;
    msg_group_mask = ~msg_group_mask;
  endtask : idle
endmodule : acf_host_model

// File: dv/action_command_filter_test.sv
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench for the action command filter
// ==========================================================================
module action_command_filter_test;
  import acf_pkg::*;
  localparam logic [31:0] DK = 32'h1234_5678;
  logic        mclk = 1'b0;
  logic        rst_n, ctrl_channel_open, unconditional_cmd_setting;
  logic        msg_valid, device_key_wr, sel_wr, group_key_wr, group_mask_wr;
  logic [31:0] msg_device_key, msg_group_key, msg_group_mask;
  logic [31:0] device_match_key, group_match_key_in, group_filter_mask_in;
  logic [31:0] group_match_key, group_filter_mask, scheduled_queue_depth;
  logic [1:0]  signal_index_select_in, signal_index_select;
  logic [3:0]  action_signal;
  int          n_fail = 0;
  int          comparisons = 0;

  always #2.5 mclk = ~mclk;

  acf_host_model HOST (.msg_valid(msg_valid), .msg_device_key(msg_device_key),
    .msg_group_key(msg_group_key), .msg_group_mask(msg_group_mask));

  acf_action_filter DUT (.mclk(mclk), .rst_n(rst_n), .msg_valid(msg_valid),
    .msg_device_key(msg_device_key), .msg_group_key(msg_group_key),
    .msg_group_mask(msg_group_mask), .ctrl_channel_open(ctrl_channel_open),
    .unconditional_cmd_setting(unconditional_cmd_setting),
    .device_key_wr(device_key_wr), .device_match_key(device_match_key),
    .sel_wr(sel_wr), .signal_index_select_in(signal_index_select_in),
    .signal_index_select(signal_index_select), .group_key_wr(group_key_wr),
    .group_match_key_in(group_match_key_in),
    .group_match_key(group_match_key), .group_mask_wr(group_mask_wr),
    .group_filter_mask_in(group_filter_mask_in),
    .group_filter_mask(group_filter_mask),
    .scheduled_queue_depth(scheduled_queue_depth),
    .action_signal(action_signal));

  // ========================================================================
  // Compare and closing tasks
  // ========================================================================
  task automatic chk_val(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t readback %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_act(input logic [3:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t action %b expected %b", $time, got, exp);
    end
  endtask : chk_act

  task automatic results();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ========================================================================
  // Access tasks, all driven on the falling edge
  // ========================================================================
  task automatic wr_dev(input logic [31:0] k);
    @(negedge mclk);
    device_match_key = k;
    device_key_wr    = 1'b1;
    @(negedge mclk);
    device_key_wr    = 1'b0;
    device_match_key = ~k;
  endtask : wr_dev

  // Select a signal, optionally write its key and mask, then read back
  task automatic cfg(input logic [1:0] s, input logic [31:0] k, m,
                     input logic wr);
    @(negedge mclk);
    signal_index_select_in = s;
    sel_wr                 = 1'b1;
    @(negedge mclk);
    sel_wr                 = 1'b0;
    group_match_key_in     = k;
    group_filter_mask_in   = m;
    group_key_wr           = wr;
    group_mask_wr          = wr;
    @(negedge mclk);
    group_key_wr           = 1'b0;
    group_mask_wr          = 1'b0;
    chk_val(32'(signal_index_select), 32'(s));
    chk_val(group_match_key, k);
    chk_val(group_filter_mask, m);
  endtask : cfg

  // One message, its pulse, then a quiet cycle
  task automatic msg(input logic [31:0] dk, gk, gm, input logic [3:0] exp);
    @(negedge mclk);
    HOST.send(dk, gk, gm);
    @(negedge mclk);
    chk_act(action_signal, exp);
    HOST.idle();
    @(negedge mclk);
    chk_act(action_signal, 4'h0);
  endtask : msg

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {rst_n, device_key_wr, sel_wr, group_key_wr, group_mask_wr} = 5'h0;
    {device_match_key, group_match_key_in, group_filter_mask_in} = 96'h0;
    signal_index_select_in    = 2'h0;
    ctrl_channel_open         = 1'b1;
    unconditional_cmd_setting = 1'b0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    chk_val(scheduled_queue_depth, 32'(ACF_QUEUE_DEPTH));
    chk_val(group_filter_mask, 32'h0);
    wr_dev(DK);
    cfg(2'h1, 32'h1, 32'h1, 1'b1);
    cfg(2'h3, 32'h1, 32'h7, 1'b1);
    cfg(2'h2, 32'h5, 32'h10, 1'b1);
    cfg(2'h0, 32'h1, 32'h2, 1'b1);
    cfg(2'h1, 32'h1, 32'h1, 1'b0);
    msg(DK, 32'h1, 32'h1, 4'hA);
    msg(DK, 32'h1, 32'h2, 4'h9);
    msg(DK, 32'h1, 32'h8, 4'h0);
    msg(DK, 32'h5, 32'hFFFF_FFFF, 4'h4);
    msg(DK, 32'h2, 32'h1, 4'h0);
    msg(DK ^ 32'h1, 32'h1, 32'h1, 4'h0);
    ctrl_channel_open = 1'b0;
    msg(DK, 32'h1, 32'h1, 4'h0);
    unconditional_cmd_setting = 1'b1;
    msg(DK, 32'h1, 32'h3, 4'hB);
    // Back to back messages, one per cycle
    @(negedge mclk);
    HOST.send(DK, 32'h1, 32'h2);
    @(negedge mclk);
    chk_act(action_signal, 4'h9);
    HOST.send(DK, 32'h5, 32'h10);
    @(negedge mclk);
    chk_act(action_signal, 4'h4);
    HOST.idle();
    @(negedge mclk);
    chk_act(action_signal, 4'h0);
    results();
  end

  // Run needs about 65 cycles; cut a hang well past that
  initial begin
    #3000;
    n_fail++;
    results();
  end
endmodule : action_command_filter_test
